//--- hdl/dwlm_pkg.sv
// package of constants and types for the drive warning limit monitor
package dwlm_pkg;
  // value widths: frequency in 0.1 Hz, current in 0.1 A, ref/feedback in 0.001 unit
  localparam int DWLM_FW = 16;
  localparam int DWLM_CW = 16;
  localparam int DWLM_RW = 32;
  // register offsets
  localparam logic [3:0] DWLM_A_CTRL = 4'h0;
  localparam logic [3:0] DWLM_A_CUR_LO = 4'h1;
  localparam logic [3:0] DWLM_A_CUR_HI = 4'h2;
  localparam logic [3:0] DWLM_A_FLOW = 4'h3;
  localparam logic [3:0] DWLM_A_FREQ_HI = 4'h4;
  localparam logic [3:0] DWLM_A_RLOW = 4'h5;
  localparam logic [3:0] DWLM_A_RHIGH = 4'h6;
  localparam logic [3:0] DWLM_A_FBLO = 4'h7;
  localparam logic [3:0] DWLM_A_FBHI = 4'h8;
  localparam logic [3:0] DWLM_A_ROUTE_A = 4'h9;
  localparam logic [3:0] DWLM_A_ROUTE_B = 4'ha;
  localparam logic [3:0] DWLM_A_ROUTE_R = 4'hb;
  localparam logic [3:0] DWLM_A_STATUS = 4'hc;
  localparam logic [3:0] DWLM_A_IRQ_CLR = 4'hd;
  localparam logic [3:0] DWLM_A_IRQ_EN = 4'he;
  localparam logic [3:0] DWLM_A_LIVE = 4'hf;
  // ctrl field positions
  localparam int DWLM_C_RANGE = 0;
  localparam int DWLM_C_NOLOAD_WARN = 1;
  localparam int DWLM_C_CLOSED = 2;
  // warning bit positions
  localparam int DWLM_W_CLOW = 0;
  localparam int DWLM_W_CHIGH = 1;
  localparam int DWLM_W_FLOW = 2;
  localparam int DWLM_W_FREQ_HI = 3;
  localparam int DWLM_W_RLOW = 4;
  localparam int DWLM_W_RHIGH = 5;
  localparam int DWLM_W_FB_LO = 6;
  localparam int DWLM_W_FB_HI = 7;
  // limits and reset values
  localparam logic [DWLM_FW-1:0] DWLM_F_MAX_LO = 16'h04b0; // 120.0 Hz
  localparam logic [DWLM_FW-1:0] DWLM_F_MAX_HI = 16'h2710; // 1000.0 Hz
  localparam logic [DWLM_FW-1:0] DWLM_FREQ_HI_RST = 16'h04b0; // 120.0 Hz
  localparam logic [DWLM_FW-1:0] DWLM_FLOW_RST = 16'h0000; // 0.0 Hz
  localparam logic [DWLM_CW-1:0] DWLM_CUR_LO_RST = 16'h0000; // 0.0 A
  localparam logic [DWLM_RW-1:0] DWLM_R_MIN = 32'hc4653601; // -999,999.999
  localparam logic [DWLM_RW-1:0] DWLM_R_MAX = 32'h3b9ac9ff; // 999,999.999
  localparam logic [2:0] DWLM_CTRL_RST = 3'h2; // 0-120 Hz, no-load warns, open loop
  // drive measurements travelling together
  typedef struct packed {
    logic [DWLM_CW-1:0] current;
    logic [DWLM_FW-1:0] freq;
    logic signed [DWLM_RW-1:0] ref_val;
    logic signed [DWLM_RW-1:0] fb;
  } dwlm_meas_s;
  // drive run state
  typedef struct packed {
    logic running;
    logic ramping;
    logic at_ref;
    logic remote_ref;
  } dwlm_run_s;
  typedef enum logic [1:0] {DWLM_IDLE, DWLM_RAMP, DWLM_ARMED} dwlm_gate_e;
endpackage

//--- hdl/dwlm_monitor.sv
// limit warning monitor with register port, routing and interrupt
//
// Decided for this implementation: the plain strobed port and the register addresses.
module dwlm_monitor
  import dwlm_pkg::*;
#(
  parameter logic [DWLM_CW-1:0] MAX_CURRENT = 16'h03e8
)(
  input wire logic mclk,
  input wire logic rst,
  input wire dwlm_meas_s meas,
  input wire dwlm_run_s run,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic [7:0] warn,
  output logic term_a,
  output logic term_b,
  output logic relay,
  output logic trip,
  output logic irq
);
  // configuration registers
  logic [2:0] ctrl, next_ctrl;
  logic [DWLM_CW-1:0] low_current_threshold, next_low_current_threshold;
  logic [DWLM_CW-1:0] high_current_threshold, next_high_current_threshold;
  logic [DWLM_FW-1:0] low_frequency_threshold, next_low_frequency_threshold;
  logic [DWLM_FW-1:0] high_frequency_threshold, next_high_frequency_threshold;
  logic signed [DWLM_RW-1:0] low_reference_threshold, next_low_reference_threshold;
  logic signed [DWLM_RW-1:0] high_reference_threshold, next_high_reference_threshold;
  logic signed [DWLM_RW-1:0] low_feedback_threshold, next_low_feedback_threshold;
  logic signed [DWLM_RW-1:0] high_feedback_threshold, next_high_feedback_threshold;
  logic [7:0] route_a, next_route_a; // warnings routed to terminal a
  logic [7:0] route_b, next_route_b; // warnings routed to terminal b
  logic [7:0] route_r, next_route_r; // warnings routed to relay
  logic [7:0] status, next_status; // sticky event bits
  logic [7:0] irq_en, next_irq_en;
  logic [31:0] next_rdata;
  // gate and flag state
  dwlm_gate_e gate, next_gate;
  logic [7:0] next_warn;
  logic next_trip;
  logic [7:0] raw; // ungated comparisons
  logic [DWLM_FW-1:0] f_ceiling; // range dependent frequency ceiling
  logic signed [DWLM_RW-1:0] wv; // write data as signed value

  assign f_ceiling = ctrl[DWLM_C_RANGE] ? DWLM_F_MAX_HI : DWLM_F_MAX_LO;
  assign wv = $signed(wdata);

  // register writes, with each threshold clamped to its legal window
  always_comb
  begin
    next_ctrl = ctrl;
    next_low_current_threshold = low_current_threshold;
    next_high_current_threshold = high_current_threshold;
    next_low_frequency_threshold = low_frequency_threshold;
    next_high_frequency_threshold = high_frequency_threshold;
    next_low_reference_threshold = low_reference_threshold;
    next_high_reference_threshold = high_reference_threshold;
    next_low_feedback_threshold = low_feedback_threshold;
    next_high_feedback_threshold = high_feedback_threshold;
    next_route_a = route_a;
    next_route_b = route_b;
    next_route_r = route_r;
    next_irq_en = irq_en;
    if (wr)
    begin
      case (addr)
        DWLM_A_CTRL: next_ctrl = wdata[2:0];
        // low current may not pass the high current threshold
        DWLM_A_CUR_LO:
        begin
          if (wdata[DWLM_CW-1:0] > high_current_threshold)
            next_low_current_threshold = high_current_threshold;
          else
            next_low_current_threshold = wdata[DWLM_CW-1:0];
        end
        DWLM_A_CUR_HI:
        begin
          if (wdata[DWLM_CW-1:0] > MAX_CURRENT)
            next_high_current_threshold = MAX_CURRENT;
          else if (wdata[DWLM_CW-1:0] < low_current_threshold)
            next_high_current_threshold = low_current_threshold;
          else
            next_high_current_threshold = wdata[DWLM_CW-1:0];
        end
        DWLM_A_FLOW:
        begin
          if (wdata[DWLM_FW-1:0] > high_frequency_threshold)
            next_low_frequency_threshold = high_frequency_threshold;
          else
            next_low_frequency_threshold = wdata[DWLM_FW-1:0];
        end
        DWLM_A_FREQ_HI:
        begin
          if (wdata[DWLM_FW-1:0] > f_ceiling)
            next_high_frequency_threshold = f_ceiling;
          else if (wdata[DWLM_FW-1:0] < low_frequency_threshold)
            next_high_frequency_threshold = low_frequency_threshold;
          else
            next_high_frequency_threshold = wdata[DWLM_FW-1:0];
        end
        DWLM_A_RLOW:
        begin
          if (wv > high_reference_threshold)
            next_low_reference_threshold = high_reference_threshold;
          else if (wv < $signed(DWLM_R_MIN))
            next_low_reference_threshold = $signed(DWLM_R_MIN);
          else
            next_low_reference_threshold = wv;
        end
        DWLM_A_RHIGH:
        begin
          if (wv < low_reference_threshold)
            next_high_reference_threshold = low_reference_threshold;
          else if (wv > $signed(DWLM_R_MAX))
            next_high_reference_threshold = $signed(DWLM_R_MAX);
          else
            next_high_reference_threshold = wv;
        end
        DWLM_A_FBLO:
        begin
          if (wv > high_feedback_threshold)
            next_low_feedback_threshold = high_feedback_threshold;
          else if (wv < $signed(DWLM_R_MIN))
            next_low_feedback_threshold = $signed(DWLM_R_MIN);
          else
            next_low_feedback_threshold = wv;
        end
        // high feedback floored by low feedback
        DWLM_A_FBHI:
        begin
          if (wv < low_feedback_threshold)
            next_high_feedback_threshold = low_feedback_threshold;
          else if (wv > $signed(DWLM_R_MAX))
            next_high_feedback_threshold = $signed(DWLM_R_MAX);
          else
            next_high_feedback_threshold = wv;
        end
        DWLM_A_ROUTE_A: next_route_a = wdata[7:0];
        DWLM_A_ROUTE_B: next_route_b = wdata[7:0];
        DWLM_A_ROUTE_R: next_route_r = wdata[7:0];
        DWLM_A_IRQ_EN: next_irq_en = wdata[7:0];
        default: ; // read-only or clear registers change nothing here
      endcase
    end
    // a range switch down must not leave the high limit above the new ceiling
    if (high_frequency_threshold > f_ceiling)
      next_high_frequency_threshold = f_ceiling;
    // low limit follows too, else the pair could cross
    if (low_frequency_threshold > f_ceiling)
      next_low_frequency_threshold = f_ceiling;
  end

  // configuration registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrl <= DWLM_CTRL_RST;
      low_current_threshold <= DWLM_CUR_LO_RST;
      high_current_threshold <= MAX_CURRENT;
      low_frequency_threshold <= DWLM_FLOW_RST;
      high_frequency_threshold <= DWLM_FREQ_HI_RST;
      low_reference_threshold <= DWLM_R_MIN;
      high_reference_threshold <= DWLM_R_MAX;
      low_feedback_threshold <= DWLM_R_MIN;
      high_feedback_threshold <= DWLM_R_MAX;
      route_a <= 8'h00;
      route_b <= 8'h00;
      route_r <= 8'h00;
      irq_en <= 8'h00;
    end
    else
    begin
      ctrl <= next_ctrl;
      low_current_threshold <= next_low_current_threshold;
      high_current_threshold <= next_high_current_threshold;
      low_frequency_threshold <= next_low_frequency_threshold;
      high_frequency_threshold <= next_high_frequency_threshold;
      low_reference_threshold <= next_low_reference_threshold;
      high_reference_threshold <= next_high_reference_threshold;
      low_feedback_threshold <= next_low_feedback_threshold;
      high_feedback_threshold <= next_high_feedback_threshold;
      route_a <= next_route_a;
      route_b <= next_route_b;
      route_r <= next_route_r;
      irq_en <= next_irq_en;
    end
  end

  always_comb
  begin
    raw = 8'h00;
    raw[DWLM_W_CLOW] = meas.current < low_current_threshold;
    raw[DWLM_W_CHIGH] = meas.current > high_current_threshold;
    raw[DWLM_W_FLOW] = meas.freq < low_frequency_threshold;
    raw[DWLM_W_FREQ_HI] = meas.freq > high_frequency_threshold;
    // remote reference only; units are the caller's scaling
    raw[DWLM_W_RLOW] = run.remote_ref && (meas.ref_val < low_reference_threshold);
    raw[DWLM_W_RHIGH] = run.remote_ref && (meas.ref_val > high_reference_threshold);
    raw[DWLM_W_FB_LO] = meas.fb < low_feedback_threshold;
    raw[DWLM_W_FB_HI] = meas.fb > high_feedback_threshold;
  end

  // enabling gate: idle while stopped, ramp until the reference is reached
  always_comb
  begin
    next_gate = gate;
    case (gate)
      DWLM_IDLE: if (run.running) next_gate = DWLM_RAMP;
      DWLM_RAMP:
      begin
        if (!run.running)
          next_gate = DWLM_IDLE;
        else if (run.at_ref && !run.ramping)
          next_gate = DWLM_ARMED;
      end
      DWLM_ARMED:
      begin
        if (!run.running)
          next_gate = DWLM_IDLE;
        else if (run.ramping)
          next_gate = DWLM_RAMP;
      end
      default: next_gate = DWLM_IDLE;
    endcase
  end

  // gated flags and no-load handling
  always_comb
  begin
    next_warn = (gate == DWLM_ARMED) ? raw : 8'h00;
    // low current only warns when no-load is set to warn
    next_warn[DWLM_W_CLOW] = next_warn[DWLM_W_CLOW] & ctrl[DWLM_C_NOLOAD_WARN];
    next_trip = trip | ((gate == DWLM_ARMED) & raw[DWLM_W_CLOW] & ~ctrl[DWLM_C_NOLOAD_WARN]);
    // sticky status, a new event wins over a clear in the same cycle
    next_status = status;
    if (wr && addr == DWLM_A_IRQ_CLR)
      next_status = status & ~wdata[7:0];
    next_status = next_status | (next_warn & ~warn);
  end

  // gate, flags, status
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      gate <= DWLM_IDLE;
      warn <= 8'h00;
      trip <= 1'b0;
      status <= 8'h00;
    end
    else
    begin
      gate <= next_gate;
      warn <= next_warn;
      trip <= next_trip;
      status <= next_status;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      term_a <= 1'b0;
      term_b <= 1'b0;
      relay <= 1'b0;
    end
    else
    begin
      term_a <= |(next_warn & route_a);
      term_b <= |(next_warn & route_b);
      relay <= |(next_warn & route_r);
    end
  end

  // level interrupt while an enabled status bit is set
  assign irq = |(status & irq_en);

  // read data, valid the cycle after the read strobe; unmapped reads zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (rd)
    begin
      case (addr)
        DWLM_A_CTRL: next_rdata = {29'h0, ctrl};
        DWLM_A_CUR_LO: next_rdata = {16'h0, low_current_threshold};
        DWLM_A_CUR_HI: next_rdata = {16'h0, high_current_threshold};
        DWLM_A_FLOW: next_rdata = {16'h0, low_frequency_threshold};
        DWLM_A_FREQ_HI: next_rdata = {16'h0, high_frequency_threshold};
        DWLM_A_RLOW: next_rdata = low_reference_threshold;
        DWLM_A_RHIGH: next_rdata = high_reference_threshold;
        DWLM_A_FBLO: next_rdata = low_feedback_threshold;
        DWLM_A_FBHI: next_rdata = high_feedback_threshold;
        DWLM_A_ROUTE_A: next_rdata = {24'h0, route_a};
        DWLM_A_ROUTE_B: next_rdata = {24'h0, route_b};
        DWLM_A_ROUTE_R: next_rdata = {24'h0, route_r};
        DWLM_A_STATUS: next_rdata = {24'h0, status};
        DWLM_A_IRQ_EN: next_rdata = {24'h0, irq_en};
        DWLM_A_LIVE: next_rdata = {21'h0, trip, gate == DWLM_ARMED, 1'b0, warn};
        default: next_rdata = 32'h0000_0000; // clear register reads zero
      endcase
    end
  end

  // read data register
  always_ff @(posedge mclk)
  begin
    if (rst)
      rdata <= 32'h0000_0000;
    else
      rdata <= next_rdata;
  end
endmodule

//--- verification/dwlm_monitor_sva.sv
// port-level concurrent checks for the warning monitor
module dwlm_monitor_sva
  import dwlm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire dwlm_meas_s meas,
  input wire dwlm_run_s run,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic [7:0] warn,
  input wire logic term_a,
  input wire logic term_b,
  input wire logic relay,
  input wire logic trip,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // one clock domain, so clocking and reset are given once
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // the gate is registered, so a flag looks back two edges at the run state
  warn_gate_a: assert property (warn != 8'h00 |->
    $past(run.running, 2) && !$past(run.ramping, 2)) else $error("warning outside run");
  // clamped thresholds make each low/high pair exclusive
  cur_pair_a: assert property (!(warn[DWLM_W_CLOW] && warn[DWLM_W_CHIGH]))
    else $error("both current warnings");
  freq_pair_a: assert property (!(warn[DWLM_W_FLOW] && warn[DWLM_W_FREQ_HI]))
    else $error("both frequency warnings");
  ref_pair_a: assert property (!(warn[DWLM_W_RLOW] && warn[DWLM_W_RHIGH]))
    else $error("both reference warnings");
  fb_pair_a: assert property (!(warn[DWLM_W_FB_LO] && warn[DWLM_W_FB_HI]))
    else $error("both feedback warnings");
  // reference flags follow the source select of the same compare edge
  ref_remote_a: assert property ((warn[DWLM_W_RLOW] || warn[DWLM_W_RHIGH]) |->
    $past(run.remote_ref)) else $error("reference warning without remote source");
  // routed outputs come from the same registered flags
  route_src_a: assert property ((term_a || term_b || relay) |-> warn != 8'h00)
    else $error("routed output without warning");
  // trip is sticky until reset
  trip_hold_a: assert property (trip |=> trip)
    else $error("trip dropped");
  // read data stands only in the cycle after the read strobe
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside its cycle");
  cov_chigh: cover property ($rose(warn[DWLM_W_CHIGH]));
  cov_trip: cover property ($rose(trip));
  cov_irq: cover property ($rose(irq));
endmodule

//--- verification/dwlm_testbench.sv
// self-checking bench for the warning monitor
module testbench;
  import dwlm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, wr, rd, term_a, term_b, relay, trip, irq;
  dwlm_meas_s meas; // measurements driven by the bench
  dwlm_run_s run; // run state driven by the bench
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  logic [7:0] warn;
  int fail_count = 0;
  int check_count = 0;
  // reset image of registers 0 to e, status and clear read zero
  localparam logic [31:0] RST_V [15] = '{32'h2, 32'h0, 32'h3e8, 32'h0, 32'h4b0,
    DWLM_R_MIN, DWLM_R_MAX, DWLM_R_MIN, DWLM_R_MAX, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0};

  dwlm_monitor #(.MAX_CURRENT(16'h03e8)) dut (.mclk(mclk), .rst(rst), .meas(meas),
    .run(run), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .warn(warn), .term_a(term_a), .term_b(term_b), .relay(relay), .trip(trip),
    .irq(irq));

  // clock of 100 ns
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // compare a register word
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("MISMATCH %0t word got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask

  // compare a flag vector
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("MISMATCH %0t flags got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask

  // one-cycle write strobe
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // one-cycle read strobe, data looked at in the following cycle only
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk32(rdata, e);
  endtask

  // write then read back the clamped value
  task automatic wr_rb(input logic [3:0] a, input logic [31:0] d, input logic [31:0] e);
    wr_reg(a, d);
    rd_chk(a, e);
  endtask

  task automatic set_run(input logic [3:0] r);
    @(posedge mclk);
    run <= r;
  endtask

  task automatic set_meas(input logic [15:0] c, input logic [15:0] f,
                          input logic [31:0] r, input logic [31:0] b);
    @(posedge mclk);
    meas <= {c, f, r, b};
  endtask

  // gate and flag register take two edges from an input change; four leave margin
  task automatic wait_chk(input int n, input logic [7:0] e);
    repeat (n) @(posedge mclk);
    #1;
    chk8(warn, e);
  endtask

  // cuts a hang short; the sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    test_done();
  end

  initial
  begin
    rst = 1'b1;
    meas = '0;
    run = '0;
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    // reset values of registers 0 to e
    for (int i = 0; i < 15; i++) rd_chk(4'(i), RST_V[i]);
    // threshold bounds, and a range change raising the high frequency ceiling
    wr_rb(DWLM_A_CUR_HI, 32'h7d0, 32'h3e8);
    wr_rb(DWLM_A_FREQ_HI, 32'h1388, 32'h4b0);
    wr_rb(DWLM_A_CTRL, 32'h3, 32'h3);
    wr_rb(DWLM_A_FREQ_HI, 32'h1388, 32'h1388);
    wr_rb(DWLM_A_FLOW, 32'h1770, 32'h1388);
    // range switch down pulls both frequency limits under the new ceiling
    wr_rb(DWLM_A_CTRL, 32'h2, 32'h2);
    rd_chk(DWLM_A_FREQ_HI, 32'h4b0);
    rd_chk(DWLM_A_FLOW, 32'h4b0);
    wr_rb(DWLM_A_FLOW, 32'h0, 32'h0);
    wr_rb(DWLM_A_FREQ_HI, 32'h258, 32'h258);
    wr_rb(DWLM_A_FLOW, 32'h64, 32'h64);
    wr_rb(DWLM_A_CUR_LO, 32'h64, 32'h64);
    wr_rb(DWLM_A_CUR_HI, 32'h1f4, 32'h1f4);
    wr_rb(DWLM_A_CUR_LO, 32'h258, 32'h1f4);
    wr_rb(DWLM_A_CUR_LO, 32'h64, 32'h64);
    wr_rb(DWLM_A_RLOW, 32'hfffffc18, 32'hfffffc18);
    wr_rb(DWLM_A_RHIGH, 32'hfffff830, 32'hfffffc18);
    wr_rb(DWLM_A_RHIGH, 32'h3e8, 32'h3e8);
    wr_rb(DWLM_A_FBLO, 32'hfffffe0c, 32'hfffffe0c);
    wr_rb(DWLM_A_FBHI, 32'h1f4, 32'h1f4);
    // high current, low frequency, high reference, low feedback
    set_meas(16'h0258, 16'h0032, 32'h7d0, 32'hfffffda8);
    wait_chk(6, 8'h00);
    set_run(4'b1101);
    wait_chk(6, 8'h00);
    set_run(4'b1011);
    wait_chk(4, 8'h66);
    // sticky status, enable and clear of the interrupt
    rd_chk(DWLM_A_STATUS, 32'h66);
    chk8({7'h0, irq}, 8'h00);
    wr_reg(DWLM_A_IRQ_EN, 32'h4);
    #1;
    chk8({7'h0, irq}, 8'h01);
    wr_reg(DWLM_A_IRQ_CLR, 32'h4);
    #1;
    chk8({7'h0, irq}, 8'h00);
    rd_chk(DWLM_A_STATUS, 32'h62);
    // routing masks to the two terminals and the relay
    wr_reg(DWLM_A_ROUTE_A, 32'h2);
    wr_reg(DWLM_A_ROUTE_B, 32'h1);
    wr_reg(DWLM_A_ROUTE_R, 32'h40);
    repeat (2) @(posedge mclk);
    #1;
    chk8({5'h0, term_a, term_b, relay}, 8'h05);
    set_run(4'b1010);
    wait_chk(4, 8'h46);
    set_run(4'b1110);
    wait_chk(4, 8'h00);
    // values equal to a threshold never warn
    set_meas(16'h01f4, 16'h0064, 32'h3e8, 32'hfffffe0c);
    set_run(4'b1011);
    wait_chk(4, 8'h00);
    set_meas(16'h0032, 16'h02bc, 32'hfffff830, 32'h258);
    wait_chk(4, 8'h99);
    chk8({5'h0, term_a, term_b, relay}, 8'h02);
    // no-load set to trip replaces the low-current warning
    wr_reg(DWLM_A_CTRL, 32'h0);
    wait_chk(4, 8'h98);
    chk8({7'h0, trip}, 8'h01);
    set_run(4'b0000);
    wait_chk(4, 8'h00);
    rd_chk(DWLM_A_LIVE, 32'h400);
    test_done();
  end
endmodule

bind dwlm_monitor dwlm_monitor_sva chk (.mclk(mclk), .rst(rst), .meas(meas),
  .run(run), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .warn(warn), .term_a(term_a), .term_b(term_b), .relay(relay), .trip(trip),
  .irq(irq));
